/* File: core/dtg_top.sv */
// dual-tone keypad generator with apb control and status
`timescale 1ns/10ps

// Functional notes
// - exactly one row and one column low means a key; starts tones
// - key lines sampled as static levels, no scanning
// - no key input: oscillator halted, tone driver off
// - columns without any row keep the oscillator stopped
// - key sensed: mute driven, oscillator started, counters loaded
// - each group steps its sine through 28 equal steps per cycle
// - rows 1..4 give 694.8, 770.1, 852.3, 940.0 Hz
// - columns 1..4 give 1206.0, 1331.7, 1486.5, 1639.0 Hz
// - output is low plus high sine, high with extra gain
// - tone enable low: oscillator stopped, tone output floats
// - tone enable high (default) gives normal tones
// - mute pulled low while any key line sensed, else open
// - mute follows keys regardless of single tone setting
// - single tone bit low: one-tone combinations give no tone
// - single bit high: several rows + one col give high, one row + several cols give low, several of both none
// - tone driver off whenever no tone is generated
module dtg_top
  import dtg_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire dtg_pkg::dtg_keys_t keys_n,
  output logic                   mute_o,
  output logic                   mute_oe_n,
  output dtg_pkg::dtg_tone_t     tone,
  output logic                   tone_oe_n
);
  import dtg_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] ones(input logic [3:0] v);
    return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction
  // lowest asserted line; callers only use it when some line is asserted
  function automatic logic [1:0] first(input logic [3:0] v);
    return v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction

  // low group ratios, line 1 in the low byte
  function automatic logic [7:0] low_ratio(input logic [1:0] i);
    logic [31:0] t;
    t = {LOW_RATIO_4, LOW_RATIO_3, LOW_RATIO_2, LOW_RATIO_1};
    return t[{i, 3'h0} +: 8];
  endfunction

  function automatic logic [7:0] high_ratio(input logic [1:0] i);
    logic [31:0] t;
    t = {HIGH_RATIO_4, HIGH_RATIO_3, HIGH_RATIO_2, HIGH_RATIO_1};
    return t[{i, 3'h0} +: 8];
  endfunction

  function automatic logic [4:0] step_adv(input logic [4:0] s);
    return (s == STEPS - 5'h1) ? 5'h0 : 5'(s + 5'h1);
  endfunction

  // quarter-wave table mirrored to 28 entries
  function automatic logic [7:0] sine_code(input logic [4:0] idx);
    logic [63:0] quarter;
    logic [4:0]  m;
    logic [2:0]  a;
    logic [7:0]  amp;
    quarter = 64'h7F7C72634F371C00;
    m       = (idx < 5'hE) ? idx : 5'(idx - 5'hE);
    a       = (m <= 5'h7) ? m[2:0] : 3'(5'hE - m);
    amp     = quarter[{a, 3'h0} +: 8];
    return (idx < 5'hE) ? 8'(SINE_MID + amp) : 8'(SINE_MID - amp);
  endfunction

  // high group weighted 11/8, about 2.8 dB of pre-emphasis
  function automatic logic [9:0] mix(input logic [7:0] lo,
                                     input logic [7:0] hi);
    int s;
    s = int'(lo) - int'(SINE_MID) + int'(SUM_MID)
        + ((int'(hi) - int'(SINE_MID)) * HI_GAIN_NUM) / HI_GAIN_DEN;
    return s[9:0];
  endfunction

  // ----------------------------------------------------------------
  // key sensing
  // ----------------------------------------------------------------
  dtg_keys_t  keys_r;
  logic [1:0] ctrl_r;
  logic [3:0] rows;
  logic [3:0] cols;
  logic       key_any;
  logic       one_r;
  logic       one_c;
  logic       many_r;
  logic       many_c;
  logic       tone_en;
  logic       single;
  logic       lo_on;
  logic       hi_on;
  logic [1:0] lo_idx;
  logic [1:0] hi_idx;
  logic [5:0] sel;

  // levels captured every rising edge, no scan sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) keys_r <= KEYS_IDLE;
    else          keys_r <= keys_n;
  end

  always_comb begin
    rows    = ~keys_r.row_n;
    cols    = ~keys_r.col_n;
    key_any = |{rows, cols};
    one_r   = ones(rows) == 3'h1;
    one_c   = ones(cols) == 3'h1;
    many_r  = ones(rows) > 3'h1;
    many_c  = ones(cols) > 3'h1;
    tone_en = ctrl_r[CTRL_TONE_EN_BIT];
    single  = ctrl_r[CTRL_SINGLE_BIT];
    lo_idx  = first(rows);
    hi_idx  = first(cols);
    lo_on   = tone_en & ((one_r & one_c) | (single & one_r & many_c));
    hi_on   = tone_en & ((one_r & one_c) | (single & many_r & one_c));
    sel     = {lo_on, lo_idx, hi_on, hi_idx};
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  dtg_state_t state_r;
  dtg_state_t state_nxt;
  logic [5:0] run_sel_r;
  logic       osc_run;

  // leave idle only on a valid tone combination
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DTG_IDLE: begin
        if (lo_on | hi_on) state_nxt = DTG_LOAD;
      end
      DTG_LOAD: state_nxt = DTG_TONE;
      DTG_TONE: begin
        if (!(lo_on | hi_on))   state_nxt = DTG_IDLE;
        else if (sel != run_sel_r) state_nxt = DTG_LOAD;
      end
      default: state_nxt = DTG_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= DTG_IDLE;
    else          state_r <= state_nxt;
  end

  assign osc_run = (state_r == DTG_TONE);

  // ----------------------------------------------------------------
  // crystal rate from the fast clock
  // ----------------------------------------------------------------
  logic [27:0] acc_r;
  logic        tick_r;
  logic [28:0] acc_sum;
  assign acc_sum = {1'b0, acc_r} + CRYSTAL_HZ;
  // accumulator held at zero while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r  <= 28'h0;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= !osc_run ? 28'h0
              : (acc_sum >= CLK_HZ) ? 28'(acc_sum - CLK_HZ) : acc_sum[27:0];
      tick_r <= osc_run && (acc_sum >= CLK_HZ);
    end
  end

  // ----------------------------------------------------------------
  // group divide counters
  // ----------------------------------------------------------------
  logic [7:0] lo_div_r;
  logic [7:0] hi_div_r;
  logic [7:0] lo_cnt_r;
  logic [7:0] hi_cnt_r;
  logic [4:0] lo_step_r;
  logic [4:0] hi_step_r;

  // load on entry, then one step per ratio crystal ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_div_r  <= LOW_RATIO_1;
      lo_cnt_r  <= 8'h0;
      lo_step_r <= 5'h0;
      run_sel_r <= 6'h0;
    end else if (state_r == DTG_LOAD) begin
      lo_div_r  <= low_ratio(lo_idx);
      lo_cnt_r  <= 8'(low_ratio(lo_idx) - 8'h1);
      lo_step_r <= 5'h0;
      run_sel_r <= sel;
    end else if (osc_run && tick_r) begin
      lo_cnt_r <= (lo_cnt_r == 8'h0) ? 8'(lo_div_r - 8'h1)
                                     : 8'(lo_cnt_r - 8'h1);
      if (lo_cnt_r == 8'h0) lo_step_r <= step_adv(lo_step_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_div_r  <= HIGH_RATIO_1;
      hi_cnt_r  <= 8'h0;
      hi_step_r <= 5'h0;
    end else if (state_r == DTG_LOAD) begin
      hi_div_r  <= high_ratio(hi_idx);
      hi_cnt_r  <= 8'(high_ratio(hi_idx) - 8'h1);
      hi_step_r <= 5'h0;
    end else if (osc_run && tick_r) begin
      hi_cnt_r <= (hi_cnt_r == 8'h0) ? 8'(hi_div_r - 8'h1)
                                     : 8'(hi_cnt_r - 8'h1);
      if (hi_cnt_r == 8'h0) hi_step_r <= step_adv(hi_step_r);
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  logic [7:0] lo_code;
  logic [7:0] hi_code;

  // a group that is off sits at the midpoint code
  assign lo_code = (osc_run && run_sel_r[5]) ? sine_code(lo_step_r)
                                             : SINE_MID;
  assign hi_code = (osc_run && run_sel_r[2]) ? sine_code(hi_step_r)
                                             : SINE_MID;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone      <= '{low_code: SINE_MID, high_code: SINE_MID,
                     sum: SUM_MID};
      tone_oe_n <= 1'b1;
    end else begin
      tone      <= '{low_code: lo_code, high_code: hi_code,
                     sum: mix(lo_code, hi_code)};
      tone_oe_n <= !osc_run;
    end
  end

  // open-drain mute, independent of tone decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_o    <= 1'b0;
      mute_oe_n <= 1'b1;
    end else begin
      mute_o    <= 1'b0;
      mute_oe_n <= !key_any;
    end
  end

  // ----------------------------------------------------------------
  // apb slave, one wait state so read data comes from a flop
  // ----------------------------------------------------------------
  logic        access;
  logic        mapped;
  logic [31:0] rd_mux;

  assign access = psel & penable;
  assign mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS)
               || (paddr == RATIO_OFS) || (paddr == STEP_OFS);

  always_comb begin
    case (paddr)
      CTRL_OFS:   rd_mux = {30'h0, ctrl_r};
      STATUS_OFS: rd_mux = {18'h0, state_r, cols, rows, hi_on, lo_on,
                            osc_run, key_any};
      RATIO_OFS:  rd_mux = {16'h0, hi_div_r, lo_div_r};
      STEP_OFS:   rd_mux = {19'h0, hi_step_r, 3'h0, lo_step_r};
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata  <= (access & ~pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // tone enable and single tone bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (access && pready && pwrite && paddr == CTRL_OFS) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  mute_on_a:
  assert property (key_any |=> !mute_oe_n)
    else $error("mute not driven while a key is sensed");
  mute_off_a:
  assert property (!key_any |=> mute_oe_n && !mute_o)
    else $error("mute driven with no key sensed");
  disable_float_a:
  assert property (!tone_en [*3] |=> tone_oe_n)
    else $error("tone driver on while disabled");
  osc_stop_a:
  assert property ((rows == 4'h0) [*3] |=> state_r == DTG_IDLE)
    else $error("oscillator running without a row");
  dual_start_a:
  assert property ((one_r && one_c && tone_en && $stable(keys_r)) [*3]
                   |=> !tone_oe_n)
    else $error("valid key did not start tones");
  step_range_a:
  assert property (lo_step_r < STEPS && hi_step_r < STEPS)
    else $error("sine step out of range");
  step_adv_a:
  assert property (osc_run && $past(osc_run)
                   && lo_step_r != $past(lo_step_r)
                   |-> lo_step_r == step_adv($past(lo_step_r)))
    else $error("low step skipped");
  ratio_load_a:
  assert property (state_r == DTG_LOAD
                   |=> lo_div_r == low_ratio($past(lo_idx))
                   && hi_div_r == high_ratio($past(hi_idx)))
    else $error("divide ratio not loaded");
  idle_code_a:
  assert property (tone_oe_n |-> tone.sum == SUM_MID)
    else $error("idle output not at midpoint");
  single_inh_a:
  assert property (!single && (many_r || many_c) |-> !lo_on && !hi_on)
    else $error("single tone not inhibited");
  apb_err_a:
  assert property (access && !pready && !mapped |=> pslverr && pready)
    else $error("unmapped access without error");

  cover property (osc_run && run_sel_r[5] && run_sel_r[2]);
  cover property (osc_run && run_sel_r[5] && !run_sel_r[2]);
  cover property (osc_run && !run_sel_r[5] && run_sel_r[2]);
  cover property (access && pready && pwrite && paddr == CTRL_OFS);

endmodule

/* File: core/dtg_pkg.sv */
// constants and carrier types of the dual-tone keypad generator
package dtg_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [28:0] CLK_HZ     = 29'h0EE6B280;
  localparam logic [28:0] CRYSTAL_HZ = 29'h0369E99;
  localparam logic [4:0]  STEPS      = 5'h1C;

  // divide ratios, crystal / (28 * tone), row and column 1..4
  localparam logic [7:0] LOW_RATIO_1  = 8'hB8;
  localparam logic [7:0] LOW_RATIO_2  = 8'hA6;
  localparam logic [7:0] LOW_RATIO_3  = 8'h96;
  localparam logic [7:0] LOW_RATIO_4  = 8'h88;
  localparam logic [7:0] HIGH_RATIO_1 = 8'h6A;
  localparam logic [7:0] HIGH_RATIO_2 = 8'h60;
  localparam logic [7:0] HIGH_RATIO_3 = 8'h56;
  localparam logic [7:0] HIGH_RATIO_4 = 8'h4E;

  // ----------------------------------------------------------------
  // output levels
  // ----------------------------------------------------------------
  localparam logic [7:0] SINE_MID    = 8'h80;
  localparam logic [9:0] SUM_MID     = 10'h200;
  localparam int         HI_GAIN_NUM = 11;
  localparam int         HI_GAIN_DEN = 8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RATIO_OFS  = 8'h08;
  localparam logic [7:0] STEP_OFS   = 8'h0C;
  localparam int         CTRL_TONE_EN_BIT = 0;
  localparam int         CTRL_SINGLE_BIT  = 1;
  localparam logic [1:0] CTRL_RESET       = 2'h1;
  localparam logic [7:0] KEYS_IDLE        = 8'hFF;

  typedef enum logic [1:0] {
    DTG_IDLE = 2'h0,
    DTG_LOAD = 2'h1,
    DTG_TONE = 2'h3
  } dtg_state_t;

  typedef struct packed {
    logic [3:0] row_n;
    logic [3:0] col_n;
  } dtg_keys_t;

  typedef struct packed {
    logic [7:0] low_code;
    logic [7:0] high_code;
    logic [9:0] sum;
  } dtg_tone_t;

endpackage

/* File: testbench/dtg_keypad_model.sv */
// keypad stand-in: closed contacts pull lines low, open lines read high
`timescale 1ns/10ps
module dtg_keypad_model
  import dtg_pkg::*;
(
  input  wire logic [3:0]    row_press,
  input  wire logic [3:0]    col_press,
  output dtg_pkg::dtg_keys_t keys_n
);
  // ----------------------------------------------------------------
  // line levels
  // ----------------------------------------------------------------
  // pull-up on open lines
  assign keys_n = '{row_n: ~row_press, col_n: ~col_press};
endmodule

/* File: testbench/dtg_keypad_tone_gen_tb_top.sv */
// self-checking bench for the dual-tone keypad generator
`timescale 1ns/10ps
module dtg_keypad_tone_gen_tb_top;
  import dtg_pkg::*;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic               pready;
  logic               pslverr;
  logic               mute_o;
  logic               mute_oe_n;
  logic               tone_oe_n;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  logic               er;
  logic [3:0]         row_press;
  logic [3:0]         col_press;
  dtg_keys_t          keys_n;
  dtg_tone_t          tone;
  int                 err_count;
  int                 check_count;
  logic [7:0]         lo_tab [4] = '{LOW_RATIO_1, LOW_RATIO_2,
                                     LOW_RATIO_3, LOW_RATIO_4};
  logic [7:0]         hi_tab [4] = '{HIGH_RATIO_1, HIGH_RATIO_2,
                                     HIGH_RATIO_3, HIGH_RATIO_4};
  localparam logic [25:0] IDLE_TONE = {SINE_MID, SINE_MID, SUM_MID};

  dtg_keypad_model pad (
    .row_press (row_press),
    .col_press (col_press),
    .keys_n    (keys_n)
  );

  dtg_top dut (
    .pclk      (pclk),
    .presetn   (presetn),
    .paddr     (paddr),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .keys_n    (keys_n),
    .mute_o    (mute_o),
    .mute_oe_n (mute_oe_n),
    .tone      (tone),
    .tone_oe_n (tone_oe_n)
  );

  // ----------------------------------------------------------------
  // clock and shared tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // change closures and let the decode and load pipeline settle
  task automatic press(input logic [3:0] r, input logic [3:0] c);
    @(posedge pclk);
    row_press <= r;
    col_press <= c;
    repeat (8) @(posedge pclk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int lo;
    int hi;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0;
    row_press = 4'h0; col_press = 4'h0;
    err_count = 0; check_count = 0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(mute_oe_n), 32'h1);
    check(32'(tone_oe_n), 32'h1);
    check(32'(tone), 32'(IDLE_TONE));
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'(CTRL_RESET));
    apb(1'b1, STATUS_OFS, 32'hFFFF);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], er}, 32'h1);
    $display("test reset and map done");

    for (int i = 0; i < 4; i++) begin
      press(4'h1 << i, 4'h8 >> i);
      check(32'(mute_oe_n), 32'h0);
      check(32'(mute_o), 32'h0);
      check(32'(tone_oe_n), 32'h0);
      apb(1'b0, RATIO_OFS, 32'h0);
      check(rd, {16'h0, hi_tab[3-i], lo_tab[i]});
      apb(1'b0, STATUS_OFS, 32'h0);
      check(rd, 32'h300F | (32'h10 << i) | (32'h800 >> i));
      press(4'h0, 4'h0);
      check(32'(tone_oe_n), 32'h1);
      check(32'(tone), 32'(IDLE_TONE));
      check(32'(mute_oe_n), 32'h1);
    end
    $display("test single keys done");

    // fastest column so one step lands well before a low step
    press(4'h1, 4'h8);
    repeat (6000) @(posedge pclk);
    apb(1'b0, STEP_OFS, 32'h0);
    check(rd, 32'h0100);
    lo = int'(tone.low_code) - int'(SINE_MID);
    hi = int'(tone.high_code) - int'(SINE_MID);
    lo = int'(SUM_MID) + lo + hi * HI_GAIN_NUM / HI_GAIN_DEN;
    check(32'(tone.sum), 32'(lo));
    // first low step near 184 ticks, high group on its second step
    repeat (7000) @(posedge pclk);
    apb(1'b0, STEP_OFS, 32'h0);
    check(rd, 32'h0201);
    $display("test stepping done");

    apb(1'b1, CTRL_OFS, 32'h0);
    press(4'h2, 4'h2);
    check(32'(tone_oe_n), 32'h1);
    check(32'(mute_oe_n), 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd & 32'hF, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h1);
    press(4'h0, 4'h5);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd & 32'hFFF, 32'h501);
    press(4'h3, 4'h1);
    check(32'(tone_oe_n), 32'h1);
    check(32'(mute_oe_n), 32'h0);
    $display("test disable and inhibit done");

    apb(1'b1, CTRL_OFS, 32'h3);
    press(4'h3, 4'h1);
    check(32'(tone_oe_n), 32'h0);
    check(32'(tone.low_code), 32'(SINE_MID));
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd & 32'hF, 32'hB);
    press(4'h4, 4'h6);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(rd & 32'hF, 32'h7);
    check(32'(tone.high_code), 32'(SINE_MID));
    apb(1'b0, RATIO_OFS, 32'h0);
    check(rd & 32'hFF, 32'(LOW_RATIO_3));
    press(4'h6, 4'h6);
    check(32'(tone_oe_n), 32'h1);
    press(4'h0, 4'h0);
    $display("test single tone enable done");
    final_report;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    final_report;
  end
endmodule
